// file: src/pms_sequencer.sv
// Mode control, power sequencing, voltage-set choice and thermal interrupt of the power unit
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

module pms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // A change counts only once the last two stages agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
        begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule : pms_sync

////////////////////////////////////////////////////////////////////////////////

module pms_sequencer #(
  parameter int BON_CYCLES = pms_pkg::BON_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Avalon-MM register slave
  input wire logic [5:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Pins and detectors
  input wire logic EN,
  input wire logic VOLTAGE_SET_SELECT_PIN,
  input wire pms_pkg::pms_strap_t STRAPS,
  input wire logic THERMAL_EARLY_WARNING,
  input wire logic THERMAL_SHUTDOWN_EVENT,
  // Power controls
  output logic BIAS_EN,
  output logic [5:0] RAIL_EN,
  output logic [5:0] RAIL_PULLDOWN,
  output logic [4:0] STEP_DOWN_VOLTAGE,
  output logic SLEEP,
  output logic [6:0] SLAVE_ADDRESS,
  output pms_pkg::pms_mode_t MODE,
  // Open-drain interrupt
  output logic IRQ_N_O,
  output logic IRQ_N_OE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic en_f;
  logic vss_f;
  logic tsd_f;
  logic ew_f;
  pms_pkg::pms_strap_t strap_f;

  pms_sync #(.W(8)) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .d({EN, VOLTAGE_SET_SELECT_PIN, THERMAL_SHUTDOWN_EVENT, THERMAL_EARLY_WARNING, STRAPS}),
    .q({en_f, vss_f, tsd_f, ew_f, strap_f})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  pms_pkg::pms_mode_t mode;
  pms_pkg::pms_setup_t setup;
  logic [7:0] regs [0:pms_pkg::NUM_RW-1];
  logic [1:0] int_mask;
  logic [1:0] int_bits;
  logic [5:0] mask;
  logic [15:0] timer;
  logic [3:0] step;
  logic [3:0] init_cnt;
  logic en_q;
  logic tsd_q;
  logic ew_q;
  logic cool_wait;
  logic ack;
  logic [3:0] idx;
  logic wr_go;
  logic rd_go;
  logic tick;
  logic en_rise;
  logic en_fall;
  logic start_req;
  logic stop_req;
  logic init_done;
  logic [5:0] in_none;
  logic [5:0] hit_start;
  logic [5:0] hit_shut;
  logic [7:0] rd_mux;
  logic [5:0] next_rail;
  logic set_a;

  ////////////////////////////////////////////////////////////////////////////////
  // Event decode

  assign en_rise = en_f & ~en_q;
  assign en_fall = ~en_f & en_q;
  assign init_done = (mode == pms_pkg::MODE_INIT) && (init_cnt == 4'(pms_pkg::INIT_CYCLES - 1));
  assign start_req = (mode == pms_pkg::MODE_STANDBY) && (en_rise || (cool_wait && !tsd_f && en_f));
  assign stop_req = ((mode == pms_pkg::MODE_BIAS) || (mode == pms_pkg::MODE_START) ||
                     (mode == pms_pkg::MODE_IDLE)) && (en_fall || tsd_f);
  assign tick = (mode == pms_pkg::MODE_BIAS) ? (timer == 16'(BON_CYCLES - 1)) :
                (timer == 16'(pms_pkg::STEP_CYCLES - 1));

  always_comb
  begin
    for (int i = 0; i < pms_pkg::NUM_RAILS; i++)
    begin
      in_none[i] = regs[i + 1][pms_pkg::F_T_HI:pms_pkg::F_T_LO] == pms_pkg::T_NONE;
      hit_start[i] = !in_none[i] && ({1'b0, regs[i + 1][pms_pkg::F_T_HI:pms_pkg::F_T_LO]} == step);
      // Reverse order: the latest startup code is the first to go
      hit_shut[i] = !in_none[i] && (step <= pms_pkg::STEP_LAST) &&
                    ({1'b0, regs[i + 1][pms_pkg::F_T_HI:pms_pkg::F_T_LO]} == pms_pkg::STEP_LAST - step);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode machine

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mode <= pms_pkg::MODE_INIT;
      timer <= '0;
      step <= '0;
      init_cnt <= '0;
      cool_wait <= 1'b0;
      en_q <= 1'b0;
      tsd_q <= 1'b0;
      ew_q <= 1'b0;
    end
    else
    begin
      en_q <= en_f;
      tsd_q <= tsd_f;
      ew_q <= ew_f;
      timer <= tick ? '0 : timer + 16'h0001;
      case (mode)
        pms_pkg::MODE_INIT:
        begin
          init_cnt <= init_cnt + 4'h1;
          en_q <= 1'b0;
          if (init_done)
          begin
            mode <= pms_pkg::MODE_STANDBY;
          end
        end
        pms_pkg::MODE_STANDBY:
        begin
          if (start_req)
          begin
            mode <= pms_pkg::MODE_BIAS;
            cool_wait <= 1'b0;
            timer <= '0;
          end
        end
        pms_pkg::MODE_BIAS, pms_pkg::MODE_START:
        begin
          if (!stop_req && tick && mode == pms_pkg::MODE_BIAS)
          begin
            mode <= pms_pkg::MODE_START;
            step <= '0;
          end
          else if (!stop_req && tick)
          begin
            if (step == pms_pkg::STEP_LAST)
            begin
              mode <= pms_pkg::MODE_IDLE;
            end
            step <= step + 4'h1;
          end
        end
        pms_pkg::MODE_SHUT:
        begin
          if (tick)
          begin
            step <= step + 4'h1;
            if (step == pms_pkg::STEP_RST_B)
            begin
              mode <= pms_pkg::MODE_STANDBY;
            end
          end
        end
        default:
        begin
        end
      endcase
      if (stop_req)
      begin
        mode <= pms_pkg::MODE_SHUT;
        step <= '0;
        timer <= '0;
        if (tsd_f)
        begin
          cool_wait <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence mask: which rails the sequencer lets follow their enable bits

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mask <= '0;
    end
    else if (stop_req)
    begin
      mask <= mask & ~in_none;
    end
    else
    begin
      case (mode)
        pms_pkg::MODE_START: mask <= mask | hit_start;
        pms_pkg::MODE_IDLE: mask <= '1;
        pms_pkg::MODE_SHUT: mask <= mask & ~hit_shut;
        default: mask <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file; writes during a sequence are accepted but may upset it

  assign idx = ADDRESS[5:2];
  assign wr_go = WRITE && ack && BYTEENABLE[0];
  assign rd_go = READ && ack;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < pms_pkg::NUM_RW; i++)
      begin
        regs[i] <= '0;
      end
      int_mask <= pms_pkg::DEF_MASK;
      setup <= pms_pkg::SETUP_HIGH;
      SLAVE_ADDRESS <= pms_pkg::SADDR_HIGH;
    end
    else if (init_done)
    begin
      // Straps are read only here, once the synchronisers have settled
      setup <= strap_f.setup_float ? pms_pkg::SETUP_FLOAT :
               strap_f.setup_high ? pms_pkg::SETUP_HIGH : pms_pkg::SETUP_LOW;
      SLAVE_ADDRESS <= strap_f.addr_float ? pms_pkg::SADDR_FLOAT :
                       strap_f.addr_high ? pms_pkg::SADDR_HIGH : pms_pkg::SADDR_LOW;
      for (int i = 0; i < pms_pkg::NUM_RW; i++)
      begin
        regs[i] <= pms_pkg::reg_default(strap_f.setup_float ? pms_pkg::SETUP_FLOAT :
                   strap_f.setup_high ? pms_pkg::SETUP_HIGH : pms_pkg::SETUP_LOW, i);
      end
      int_mask <= pms_pkg::DEF_MASK;
    end
    else if (mode == pms_pkg::MODE_SHUT && tick && step == pms_pkg::STEP_RST_A)
    begin
      regs[pms_pkg::IDX_PULLDOWN] <= pms_pkg::reg_default(setup, pms_pkg::IDX_PULLDOWN);
      int_mask <= pms_pkg::DEF_MASK;
    end
    else if (mode == pms_pkg::MODE_SHUT && tick && step == pms_pkg::STEP_RST_B)
    begin
      for (int i = 0; i < pms_pkg::NUM_RW - 1; i++)
      begin
        regs[i] <= pms_pkg::reg_default(setup, i);
      end
    end
    else if (wr_go && mode != pms_pkg::MODE_INIT)
    begin
      // Standby and idle both take new settings
      if (idx < 4'(pms_pkg::NUM_RW))
      begin
        regs[idx] <= WRITEDATA[7:0];
      end
      else if (idx == pms_pkg::IDX_MASK)
      begin
        int_mask <= WRITEDATA[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, read data from a flop

  always_comb
  begin
    rd_mux = '0;
    if (idx < 4'(pms_pkg::NUM_RW))
    begin
      rd_mux = regs[idx];
    end
    else if (idx == pms_pkg::IDX_STATUS)
    begin
      rd_mux = {6'h00, tsd_f, ew_f};
    end
    else if (idx == pms_pkg::IDX_INT)
    begin
      rd_mux = {6'h00, int_bits};
    end
    else if (idx == pms_pkg::IDX_MASK)
    begin
      rd_mux = {6'h00, int_mask};
    end
  end

  assign WAITREQUEST = (READ || WRITE) && !ack;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ack <= 1'b0;
      READDATA <= '0;
    end
    else
    begin
      ack <= (READ || WRITE) && !ack;
      if (READ && !ack)
      begin
        READDATA <= {24'h000000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Thermal interrupt; a new event beats a clearing read in the same cycle

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      int_bits <= '0;
      IRQ_N_OE <= 1'b0;
    end
    else
    begin
      int_bits <= (int_bits & ~{2{rd_go && idx == pms_pkg::IDX_INT}}) |
                  {tsd_f & ~tsd_q, ew_f & ~ew_q};
      IRQ_N_OE <= |(int_bits & ~int_mask);
    end
  end

  assign IRQ_N_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Power outputs

  assign set_a = regs[pms_pkg::IDX_GENERAL][pms_pkg::F_EXT_DVS] ? vss_f :
                 regs[pms_pkg::IDX_ENABLE][pms_pkg::F_SET_CHOICE];
  assign next_rail = regs[pms_pkg::IDX_ENABLE][5:0] & mask;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RAIL_EN <= '0;
      RAIL_PULLDOWN <= '0;
      BIAS_EN <= 1'b0;
      STEP_DOWN_VOLTAGE <= '0;
      SLEEP <= 1'b0;
      MODE <= pms_pkg::MODE_INIT;
    end
    else
    begin
      RAIL_EN <= next_rail;
      RAIL_PULLDOWN <= regs[pms_pkg::IDX_PULLDOWN][5:0] & ~next_rail;
      BIAS_EN <= (mode != pms_pkg::MODE_INIT) && (mode != pms_pkg::MODE_STANDBY);
      STEP_DOWN_VOLTAGE <= set_a ? regs[pms_pkg::IDX_BUCK_A][pms_pkg::F_V_HI:pms_pkg::F_V_LO] :
                           regs[pms_pkg::IDX_BUCK_B][pms_pkg::F_V_HI:pms_pkg::F_V_LO];
      // Sleep only means something while rails are up
      SLEEP <= (mode == pms_pkg::MODE_IDLE) &&
               (regs[pms_pkg::IDX_GENERAL][pms_pkg::F_EXT_SLEEP] ? !vss_f :
                regs[pms_pkg::IDX_ENABLE][pms_pkg::F_SLEEP_MODE]);
      MODE <= mode;
    end
  end

endmodule : pms_sequencer

// file: src/pms_pkg.sv
// Shared constants, types and register defaults of the mode and power sequencer
package pms_pkg;

  typedef enum logic [1:0] {SETUP_HIGH, SETUP_LOW, SETUP_FLOAT} pms_setup_t;
  typedef enum logic [2:0] {MODE_INIT, MODE_STANDBY, MODE_BIAS, MODE_START, MODE_IDLE, MODE_SHUT} pms_mode_t;

  // Three-level strap pins arrive as a level plus a floating indication
  typedef struct packed {
    logic setup_high;
    logic setup_float;
    logic addr_high;
    logic addr_float;
  } pms_strap_t;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int T_STEP_NS = 25000;
  localparam int STEP_CYCLES = (T_STEP_NS * CLK_MHZ) / 1000;
  localparam int T_BON_MIN_NS = 100000;
  localparam int T_BON_NS = 150000;
  localparam int T_BON_MAX_NS = 200000;
  localparam int BON_CYCLES = (T_BON_NS * CLK_MHZ) / 1000;
  localparam int T_POR_MAX_NS = 500000;
  localparam int INIT_CYCLES = 8;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_GENERAL = 4'h0;
  localparam logic [3:0] IDX_BUCK_A = 4'h6;
  localparam logic [3:0] IDX_BUCK_B = 4'h7;
  localparam logic [3:0] IDX_ENABLE = 4'h8;
  localparam logic [3:0] IDX_PULLDOWN = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_INT = 4'hB;
  localparam logic [3:0] IDX_MASK = 4'hC;
  localparam int NUM_RW = 10;

  // Field positions
  localparam int F_EXT_DVS = 2;
  localparam int F_EXT_SLEEP = 1;
  localparam int F_SET_CHOICE = 7;
  localparam int F_SLEEP_MODE = 6;
  localparam int F_T_HI = 7;
  localparam int F_T_LO = 5;
  localparam int F_V_HI = 4;
  localparam int F_V_LO = 0;
  localparam int NUM_RAILS = 6;

  // Sequence codes: delay code 7 keeps an output out of the sequence
  localparam logic [2:0] T_NONE = 3'h7;
  localparam logic [3:0] STEP_LAST = 4'h6;
  localparam logic [3:0] STEP_RST_A = 4'h7;
  localparam logic [3:0] STEP_RST_B = 4'h8;

  // Slave addresses
  localparam logic [6:0] SADDR_HIGH = 7'h7F;
  localparam logic [6:0] SADDR_FLOAT = 7'h7C;
  localparam logic [6:0] SADDR_LOW = 7'h7D;

  // Reset values, registers 0x00 to 0x09, then the mask
  localparam logic [7:0] DEF_HIGH [0:9] = '{8'h01, 8'h7D, 8'h75, 8'h6C, 8'h63, 8'hFF, 8'hE5, 8'h05, 8'h8F, 8'h3F};
  localparam logic [7:0] DEF_LOW [0:9] = '{8'h05, 8'hFD, 8'hFD, 8'h75, 8'hFA, 8'hFF, 8'hEB, 8'h09, 8'h84, 8'h3F};
  localparam logic [7:0] DEF_FLOAT [0:9] = '{8'h01, 8'h79, 8'h75, 8'h6C, 8'h65, 8'hFF, 8'hE9, 8'h09, 8'h8F, 8'h3F};
  localparam logic [1:0] DEF_MASK = 2'h3;

  function automatic logic [7:0] reg_default(input pms_setup_t s, input int i);
    logic [7:0] v;
    case (s)
      SETUP_HIGH: v = DEF_HIGH[i];
      SETUP_LOW: v = DEF_LOW[i];
      default: v = DEF_FLOAT[i];
    endcase
    return v;
  endfunction : reg_default

endpackage : pms_pkg

// file: tb/pms_sequencer_asserts.sv
// Concurrent checks on the ports of the power sequencer
`timescale 1ns/10ps

module pms_sequencer_asserts #(
  parameter int BON_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Pins
  input wire logic EN,
  input wire pms_pkg::pms_strap_t STRAPS,
  input wire logic THERMAL_SHUTDOWN_EVENT,
  // Outputs
  input wire logic BIAS_EN,
  input wire logic [5:0] RAIL_EN,
  input wire logic SLEEP,
  input wire logic [6:0] SLAVE_ADDRESS,
  input wire pms_pkg::pms_mode_t MODE,
  input wire logic IRQ_N_O,
  input wire logic IRQ_N_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic [15:0] bias_cnt;
  logic [15:0] start_cnt;
  logic [15:0] shut_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles spent in each timed mode; cleared on leaving it
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bias_cnt <= 16'h0000;
      start_cnt <= 16'h0000;
      shut_cnt <= 16'h0000;
    end
    else
    begin
      bias_cnt <= (MODE == pms_pkg::MODE_BIAS) ? bias_cnt + 16'h0001 : 16'h0000;
      start_cnt <= (MODE == pms_pkg::MODE_START) ? start_cnt + 16'h0001 : 16'h0000;
      shut_cnt <= (MODE == pms_pkg::MODE_SHUT) ? shut_cnt + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_por;
    $rose(ARST_N) |-> ##[1:16] MODE == pms_pkg::MODE_STANDBY;
  endproperty
  a_por: assert property (p_por) else $error("standby not reached after reset");
  property p_standby;
    MODE == pms_pkg::MODE_STANDBY && $past(MODE) == pms_pkg::MODE_STANDBY |-> RAIL_EN == 6'h00 && !BIAS_EN;
  endproperty
  a_standby: assert property (p_standby) else $error("power active in standby");
  property p_bias;
    $past(MODE) == pms_pkg::MODE_BIAS && MODE == pms_pkg::MODE_START |->
      bias_cnt >= BON_CYCLES - 1 && bias_cnt <= BON_CYCLES + 1;
  endproperty
  a_bias: assert property (p_bias) else $error("bias interval wrong");
  // Rails only rise at a step boundary and never drop while starting up
  property p_rails;
    $past(MODE) == pms_pkg::MODE_START && MODE == pms_pkg::MODE_START |-> ($past(RAIL_EN) & ~RAIL_EN) == 6'h00
      && (RAIL_EN == $past(RAIL_EN) || start_cnt % 2500 <= 2);
  endproperty
  a_rails: assert property (p_rails) else $error("rail change off step");
  property p_start;
    $past(MODE) == pms_pkg::MODE_START && MODE == pms_pkg::MODE_IDLE |-> start_cnt inside {[16'h445B:16'h445E]};
  endproperty
  a_start: assert property (p_start) else $error("startup length wrong");
  property p_shut;
    $past(MODE) == pms_pkg::MODE_SHUT && MODE == pms_pkg::MODE_STANDBY |-> shut_cnt inside {[16'h57E3:16'h57E6]};
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown length wrong");
  property p_en_fall;
    $fell(EN) && MODE == pms_pkg::MODE_IDLE |-> ##[1:8] MODE == pms_pkg::MODE_SHUT;
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("no shutdown on enable fall");
  property p_hot;
    $rose(THERMAL_SHUTDOWN_EVENT) && MODE == pms_pkg::MODE_IDLE |-> ##[1:8] MODE == pms_pkg::MODE_SHUT;
  endproperty
  a_hot: assert property (p_hot) else $error("no shutdown on overheat");
  property p_sleep;
    SLEEP |-> MODE == pms_pkg::MODE_IDLE || $past(MODE) == pms_pkg::MODE_IDLE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outside idle");
  property p_addr;
    MODE != pms_pkg::MODE_INIT && $past(MODE) != pms_pkg::MODE_INIT |->
      SLAVE_ADDRESS == (STRAPS.addr_float ? 7'h7C : (STRAPS.addr_high ? 7'h7F : 7'h7D));
  endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_od;
    IRQ_N_O == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("interrupt drives high");
  c_idle: cover property (MODE == pms_pkg::MODE_IDLE);
  c_shut: cover property (MODE == pms_pkg::MODE_SHUT);
  c_irq: cover property (IRQ_N_OE);
endmodule : pms_sequencer_asserts

// file: tb/pms_host.sv
// Host controller model: register master and pulled-up interrupt line
`timescale 1ns/10ps

module pms_host (
  // Clock
  input wire logic clk,
  // Register master
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Open-drain interrupt
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic irq_line
);
  initial
  begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h00000000;
  end

  // External pull-up gives the high level
  assign irq_line = (irq_n_oe && !irq_n_o) ? 1'b0 : 1'b1;

  // Callers keep away from running sequences, whose state writes could upset
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {24'h000000, d};
    // Waitrequest is looked at on the rising edge, where the slave takes the request
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    address <= ~address;
    writedata <= ~writedata;
  endtask : xfer
endmodule : pms_host

// file: tb/pms_sequencer_tb.sv
// Self-checking testbench of the power sequencer
`timescale 1ns/10ps

module pms_sequencer_tb;
  localparam int BON = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b0;
  logic vsel = 1'b1;
  logic warn = 1'b0;
  logic hot = 1'b0;
  pms_pkg::pms_strap_t straps = 4'h9;
  logic [5:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic bias_en;
  logic [5:0] rail_en;
  logic [5:0] pdn;
  logic [4:0] vout;
  logic sleep;
  logic [6:0] saddr;
  pms_pkg::pms_mode_t mode;
  logic irq_o;
  logic irq_oe;
  logic irq_line;
  logic [7:0] q;
  int n;
  int num_errors = 0;
  int comparisons = 0;
  logic [3:0] s_tab [3] = '{4'h0, 4'h6, 4'h9};
  logic [6:0] a_tab [3] = '{7'h7D, 7'h7F, 7'h7C};
  logic [7:0] e_tab [3] = '{8'h84, 8'h8F, 8'h8F};

  always #5 clk = ~clk;

  pms_sequencer #(.BON_CYCLES(BON)) u_dut (.CLK(clk), .ARST_N(arst_n), .ADDRESS(address), .READ(read),
    .WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
    .EN(en), .VOLTAGE_SET_SELECT_PIN(vsel), .STRAPS(straps), .THERMAL_EARLY_WARNING(warn),
    .THERMAL_SHUTDOWN_EVENT(hot), .BIAS_EN(bias_en), .RAIL_EN(rail_en), .RAIL_PULLDOWN(pdn),
    .STEP_DOWN_VOLTAGE(vout), .SLEEP(sleep), .SLAVE_ADDRESS(saddr), .MODE(mode), .IRQ_N_O(irq_o),
    .IRQ_N_OE(irq_oe));

  pms_host u_host (.clk(clk), .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq_n_o(irq_o),
    .irq_n_oe(irq_oe), .irq_line(irq_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    u_host.xfer(1'b0, idx, 8'h00, d);
  endtask : rd

  task automatic wait_mode(input pms_pkg::pms_mode_t m, input int lim, output int c);
    c = 0;
    while (mode !== m && c < lim)
    begin
      @(negedge clk);
      c++;
    end
  endtask : wait_mode

  task automatic wait_rail(input logic [5:0] v, input int lim, output int c);
    c = 0;
    while (rail_en !== v && c < lim)
    begin
      @(negedge clk);
      c++;
    end
  endtask : wait_rail

  task automatic settle;
    repeat (10) @(negedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // Straps are sampled only once, so each setting needs its own reset
  task automatic t_straps;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      arst_n <= 1'b0;
      straps <= s_tab[i];
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      wait_mode(pms_pkg::MODE_STANDBY, 50000, n);
      check(mode, pms_pkg::MODE_STANDBY);
      check(saddr, a_tab[i]);
      check({bias_en, rail_en}, 7'h00);
      rd(4'h8, q);
      check(q, e_tab[i]);
    end
  endtask : t_straps

  task automatic t_regs;
    wr(4'h7, 8'h03);
    rd(4'h7, q);
    check(q, 8'h03);
    rd(4'hE, q);
    check(q, 8'h00);
    wr(4'hA, 8'hFF);
    rd(4'hA, q);
    check(q, 8'h00);
  endtask : t_regs

  task automatic t_startup;
    @(posedge clk);
    en <= 1'b1;
    wait_mode(pms_pkg::MODE_BIAS, 20, n);
    check(mode, pms_pkg::MODE_BIAS);
    wait_mode(pms_pkg::MODE_START, 200, n);
    check(n >= BON - 1 && n <= BON + 1, 1);
    wait_rail(6'h0F, 8000, n);
    check(n >= 7498 && n <= 7503, 1);
    check(rail_en, 6'h0F);
    wait_mode(pms_pkg::MODE_IDLE, 11000, n);
    check(n >= 9995 && n <= 10005, 1);
  endtask : t_startup

  task automatic t_idle;
    wr(4'h8, 8'h9F);
    settle();
    check({rail_en, vout}, {6'h1F, 5'h05});
    check(pdn, 6'h20);
    wr(4'h8, 8'h1F);
    settle();
    check(vout, 5'h03);
    wr(4'h0, 8'h05);
    settle();
    check(vout, 5'h05);
    @(posedge clk);
    vsel <= 1'b0;
    settle();
    check(vout, 5'h03);
    wr(4'h8, 8'h5F);
    settle();
    check(sleep, 1'b1);
    wr(4'h8, 8'h9F);
    wr(4'h0, 8'h07);
    settle();
    check(sleep, 1'b1);
    @(posedge clk);
    vsel <= 1'b1;
    settle();
    check({sleep, vout}, {1'b0, 5'h05});
  endtask : t_idle

  task automatic t_irq;
    @(posedge clk);
    warn <= 1'b1;
    settle();
    check(irq_line, 1'b1);
    @(posedge clk);
    warn <= 1'b0;
    rd(4'hB, q);
    wr(4'hC, 8'h00);
    @(posedge clk);
    warn <= 1'b1;
    settle();
    check(irq_line, 1'b0);
    rd(4'hB, q);
    check(q, 8'h01);
    settle();
    check(irq_line, 1'b1);
    @(posedge clk);
    warn <= 1'b0;
  endtask : t_irq

  task automatic t_shutdown;
    @(posedge clk);
    en <= 1'b0;
    repeat (8) @(negedge clk);
    check({mode, rail_en}, {pms_pkg::MODE_SHUT, 6'h0F});
    wait_rail(6'h00, 8000, n);
    check(n >= 4900 && n <= 7600, 1);
    wait_mode(pms_pkg::MODE_STANDBY, 20000, n);
    rd(4'hC, q);
    check(q, 8'h03);
    rd(4'h8, q);
    check(q, 8'h8F);
    rd(4'h7, q);
    check(q, 8'h05);
  endtask : t_shutdown

  task automatic t_thermal;
    @(posedge clk);
    en <= 1'b1;
    wait_mode(pms_pkg::MODE_IDLE, 20000, n);
    @(posedge clk);
    hot <= 1'b1;
    wait_mode(pms_pkg::MODE_SHUT, 10, n);
    check(mode, pms_pkg::MODE_SHUT);
    wait_mode(pms_pkg::MODE_STANDBY, 25000, n);
    repeat (50) @(negedge clk);
    check(mode, pms_pkg::MODE_STANDBY);
    @(posedge clk);
    hot <= 1'b0;
    wait_mode(pms_pkg::MODE_BIAS, 20, n);
    check(mode, pms_pkg::MODE_BIAS);
  endtask : t_thermal

  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_straps();
    t_regs();
    t_startup();
    t_idle();
    t_irq();
    t_shutdown();
    t_thermal();
    wrap_up();
  end

  // Whole run needs about 80400 cycles
  initial
  begin
    #950000;
    num_errors++;
    wrap_up();
  end
endmodule : pms_sequencer_tb

bind pms_sequencer pms_sequencer_asserts #(.BON_CYCLES(BON_CYCLES)) u_chk (.CLK(CLK), .ARST_N(ARST_N), .EN(EN),
  .STRAPS(STRAPS), .THERMAL_SHUTDOWN_EVENT(THERMAL_SHUTDOWN_EVENT), .BIAS_EN(BIAS_EN), .RAIL_EN(RAIL_EN),
  .SLEEP(SLEEP), .SLAVE_ADDRESS(SLAVE_ADDRESS), .MODE(MODE), .IRQ_N_O(IRQ_N_O), .IRQ_N_OE(IRQ_N_OE));
